// ### rtl/csp_pkg.sv
// Shared constants and types for the clocked serial port
package csp_pkg;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_PIN_FUNC = 6'h04;
   localparam logic [5:0] IDX_CTL_A = 6'h05;
   localparam logic [5:0] IDX_SHIFT_LOW = 6'h06;
   localparam logic [5:0] IDX_SHIFT_HIGH = 6'h07;
   localparam logic [5:0] IDX_MISC = 6'h0C;
   localparam logic [5:0] IDX_CTL_B = 6'h28;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h30;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
   localparam logic [5:0] IDX_START = 6'h32;
   localparam logic [5:0] IDX_STATUS = 6'h33;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Field positions
   localparam int CTLA_INT_CLK = 3;
   localparam int CTLB_RANGE = 0;
   localparam int CTLB_IDLE = 1;
   localparam int IRQ_SERIAL = 2;
   localparam int START_GO = 0;
   localparam logic [3:0] IRQ_SERIAL_SET = 4'h4;

   // Reset values
   localparam logic [3:0] RST_PIN_FUNC = 4'h0;
   localparam logic [3:0] RST_CTL_A = 4'h0;
   localparam logic [3:0] RST_MISC = 4'h0;
   localparam logic [3:0] RST_IRQ = 4'h0;
   localparam logic [7:0] RST_SHIFT = 8'h00;
   localparam logic RST_RANGE = 1'b0;
   localparam logic RST_IDLE_LEVEL = 1'b1;

   // Pin function modes with internal clock
   localparam logic [1:0] MODE_CONT = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h1;
   localparam logic [1:0] MODE_RX = 2'h2;
   localparam logic [1:0] MODE_TXRX = 2'h3;

   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_LAST = 3'h7;

   // Prescaler: half period is 2**exp instruction cycles
   localparam logic [2:0] SEL_LAST_PRE = 3'h5;
   localparam logic [3:0] PRE_HALF_TOP = 4'hB;
   localparam logic [3:0] SYS_HALF_EXP = 4'h0;
   localparam int PRE_CNT_W = 13;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_XFER = 2'b10,
      ST_CONT = 2'b11
   } csp_state_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } csp_sck_evt_t;
endpackage

// ### rtl/csp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= RST_VAL;
         dout <= RST_VAL;
      end else if (ce) begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### rtl/csp_prescaler.sv
// Internal shift clock generator: prescaler or system clock
`timescale 1ns/1ps
`default_nettype none
module csp_prescaler (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic range,
   output csp_pkg::csp_sck_evt_t evt,
   output logic level
);
   logic [csp_pkg::PRE_CNT_W-1:0] cnt_reg;
   logic level_reg;

   // Selectors above the prescaler codes pick the system clock
   wire logic [3:0] halfExp = (sel > csp_pkg::SEL_LAST_PRE) ?
      csp_pkg::SYS_HALF_EXP :
      csp_pkg::PRE_HALF_TOP - {sel, 1'b0} + {3'h0, range};
   wire logic [csp_pkg::PRE_CNT_W-1:0] halfLast =
      (13'h0001 << halfExp) - 13'h0001;
   // >= so that a shortened ratio never waits for a wrap
   wire logic tick = run && (cnt_reg >= halfLast);

   assign evt = '{rise: tick & ~level_reg, fall: tick & level_reg};
   assign level = level_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 13'h0000;
         level_reg <= 1'b1;
      end else if (ce) begin
         if (!run) begin
            cnt_reg <= 13'h0000;
            level_reg <= 1'b1;
         end else if (tick) begin
            cnt_reg <= 13'h0000;
            level_reg <= ~level_reg;
         end else begin
            cnt_reg <= cnt_reg + 13'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/csp_serial_port.sv
// Clocked 8-bit serial port with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R01) One 8-bit word moves per transfer through the shift register.
// (R02) Shift clock comes from clock pin, prescaler or system clock.
// (R03) Any write to control A initialises the port.
// (R04) Control A picks clock pin role; pin function picks data pins.
// (R05) Clock source chosen by control A and control B together.
// (R06) Shift register writes load, reads return; shifts once per clock.
// (R07) Data out level undefined until first bit or idle level setting.
// (R08) Start command activates port and clears the counter.
// (R09) Counter increments on each rising shift clock edge in transfer.
// (R10) Eighth clock or abort clears counter, sets flag, stops transfer.
// (R11) Prescaler clock period spans 4 to 8192 instruction cycles.
// (R12) Internal clock: modes continuous, transmit only, receive only.
// (R13) Software sets data out level while port is idle.
// (R14) Send LSB first on falling edge, sample LSB first on rising.
// (R15) Control A write stops shifting, clears counter, flags if busy.
// (R16) Pin function code 11 gives combined transmit and receive.
// (R17) Internal clock stops after eight clocks of a transfer.
// (R18) Three-bit counter wraps 111 to 000 marking end of transfer.
// (R19) External clock gives eight pulses per transfer, idles high.
module csp_serial_port (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic shiftClockIn,
   output logic shiftClockOut,
   output logic shiftClockOe_b,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutOe_b,
   output logic irq
);
   logic awFree_reg, wFree_reg, arFree_reg;
   logic [7:0] awAddr_reg, shift_reg;
   logic [31:0] wData_reg, rdVal;
   logic [3:0] wStrb_reg;
   logic [3:0] pinFunc_reg, ctlA_reg, misc_reg, irqStat_reg, irqMask_reg;
   logic range_reg, idleLevel_reg, sckPrev_reg, preLevel, rdOk;
   logic [2:0] cnt_reg, cnt_next;
   csp_pkg::csp_state_t state_reg, state_next;
   logic [1:0] pinSync;
   csp_pkg::csp_sck_evt_t preEvt;

   // Clock pin idles high, so the synchroniser resets high as well
   csp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .din({shiftClockIn, serialIn}),
      .dout(pinSync)
   ); // see (R19)
   wire logic sckSync = pinSync[1];
   wire logic siSync = pinSync[0];

   // Bus decode
   wire logic [5:0] wIdx = awAddr_reg[7:2];
   wire logic [5:0] rIdx = s_axi_araddr[7:2];
   wire logic [3:0] wNib = wData_reg[3:0];
   wire logic awTake = s_axi_awvalid & awFree_reg;
   wire logic wTake = s_axi_wvalid & wFree_reg;
   wire logic arTake = s_axi_arvalid & arFree_reg;
   wire logic doWrite = ~awFree_reg & ~wFree_reg & ~s_axi_bvalid;
   wire logic wrEn = doWrite & wStrb_reg[0];
   wire logic wrPin = wrEn && (wIdx == csp_pkg::IDX_PIN_FUNC);
   wire logic wrCtlA = wrEn && (wIdx == csp_pkg::IDX_CTL_A);
   wire logic wrLow = wrEn && (wIdx == csp_pkg::IDX_SHIFT_LOW);
   wire logic wrHigh = wrEn && (wIdx == csp_pkg::IDX_SHIFT_HIGH);
   wire logic wrMisc = wrEn && (wIdx == csp_pkg::IDX_MISC);
   wire logic wrCtlB = wrEn && (wIdx == csp_pkg::IDX_CTL_B);
   wire logic wrStat = wrEn && (wIdx == csp_pkg::IDX_IRQ_STAT);
   wire logic wrMask = wrEn && (wIdx == csp_pkg::IDX_IRQ_MASK);
   wire logic wrStart = wrEn && (wIdx == csp_pkg::IDX_START);
   wire logic wMapped = wIdx inside {csp_pkg::IDX_PIN_FUNC, csp_pkg::IDX_CTL_A,
      csp_pkg::IDX_SHIFT_LOW, csp_pkg::IDX_SHIFT_HIGH, csp_pkg::IDX_MISC,
      csp_pkg::IDX_CTL_B, csp_pkg::IDX_IRQ_STAT, csp_pkg::IDX_IRQ_MASK,
      csp_pkg::IDX_START, csp_pkg::IDX_STATUS};

   // Shift clock source and mode
   wire logic intClk = ctlA_reg[csp_pkg::CTLA_INT_CLK];
   wire logic active = state_reg != csp_pkg::ST_IDLE;
   wire logic [1:0] mode = pinFunc_reg[1:0];
   wire logic txEn = (mode == csp_pkg::MODE_TX) ||
      (mode == csp_pkg::MODE_TXRX); // see (R12) see (R16)
   wire logic rxEn = (mode == csp_pkg::MODE_RX) ||
      (mode == csp_pkg::MODE_TXRX); // see (R12) see (R16)
   wire logic contMode = intClk && (mode == csp_pkg::MODE_CONT); // see (R12)

   csp_prescaler u_prescaler (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .run(intClk & active), // see (R17)
      .sel(ctlA_reg[2:0]), // see (R05) see (R11)
      .range(range_reg),
      .evt(preEvt),
      .level(preLevel)
   );

   wire logic extRise = sckSync & ~sckPrev_reg;
   wire logic extFall = ~sckSync & sckPrev_reg;
   wire logic sckRise = intClk ? preEvt.rise : extRise; // see (R02)
   wire logic sckFall = intClk ? preEvt.fall : extFall; // see (R02)

   wire logic inXfer = state_reg == csp_pkg::ST_XFER;
   wire logic stsCmd = wrStart & wNib[csp_pkg::START_GO];
   wire logic stsTake = stsCmd && (state_reg != csp_pkg::ST_CONT);
   wire logic lastRise = inXfer && sckRise && (cnt_reg == csp_pkg::CNT_LAST);
   wire logic firstFall = (state_reg == csp_pkg::ST_WAIT) && sckFall &&
      !contMode;
   wire logic shiftOut = (firstFall | (inXfer & sckFall)) & txEn;
   wire logic shiftIn = inXfer & sckRise;
   wire logic abortXfer = inXfer & (wrCtlA | stsTake); // see (R15)
   wire logic serialEvt = lastRise | abortXfer; // see (R10)
   wire logic ctlBOpen = wrCtlB & ~inXfer;
   wire logic idleLoad = ctlBOpen && (state_reg == csp_pkg::ST_IDLE);
   wire logic [3:0] irqClr = wrStat ? wNib : 4'h0;
   wire logic [3:0] irqSet = serialEvt ? csp_pkg::IRQ_SERIAL_SET : 4'h0;
   // Set wins over a clear landing in the same cycle
   wire logic [3:0] irqStatNext = (irqStat_reg & ~irqClr) | irqSet;

   always_comb begin
      state_next = state_reg;
      if (wrCtlA) begin
         state_next = csp_pkg::ST_IDLE; // see (R03)
      end else if (stsTake) begin
         state_next = csp_pkg::ST_WAIT; // see (R08)
      end else begin
         unique case (state_reg)
            csp_pkg::ST_IDLE: state_next = csp_pkg::ST_IDLE;
            csp_pkg::ST_WAIT: begin
               if (sckFall) begin
                  state_next = contMode ? csp_pkg::ST_CONT :
                     csp_pkg::ST_XFER;
               end
            end
            csp_pkg::ST_XFER: begin
               // Internal clock ends idle; external waits for more
               if (lastRise) begin
                  state_next = intClk ? csp_pkg::ST_IDLE :
                     csp_pkg::ST_WAIT; // see (R17)
               end
            end
            csp_pkg::ST_CONT: state_next = csp_pkg::ST_CONT;
         endcase
      end
   end

   always_comb begin
      cnt_next = cnt_reg;
      if (wrCtlA | stsTake) begin
         cnt_next = csp_pkg::CNT_ZERO; // see (R08) see (R15)
      end else if (shiftIn) begin
         cnt_next = cnt_reg + 3'h1; // see (R09) see (R18)
      end
   end

   always_comb begin
      rdOk = 1'b1;
      unique case (rIdx)
         csp_pkg::IDX_PIN_FUNC: rdVal = {28'h0, pinFunc_reg};
         csp_pkg::IDX_SHIFT_LOW: rdVal = {28'h0, shift_reg[3:0]}; // see (R06)
         csp_pkg::IDX_SHIFT_HIGH: rdVal = {28'h0, shift_reg[7:4]};
         csp_pkg::IDX_MISC: rdVal = {28'h0, misc_reg};
         csp_pkg::IDX_IRQ_STAT: rdVal = {28'h0, irqStat_reg};
         csp_pkg::IDX_IRQ_MASK: rdVal = {28'h0, irqMask_reg};
         csp_pkg::IDX_STATUS: rdVal = {27'h0, state_reg, cnt_reg};
         csp_pkg::IDX_CTL_A, csp_pkg::IDX_CTL_B, csp_pkg::IDX_START: begin
            rdVal = 32'h0;
         end
         default: begin
            rdVal = 32'h0;
            rdOk = 1'b0;
         end
      endcase
   end

   // Write channels
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awFree_reg <= 1'b1;
         wFree_reg <= 1'b1;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= csp_pkg::RESP_OKAY;
      end else if (ce) begin
         if (awTake) begin
            awFree_reg <= 1'b0;
            awAddr_reg <= s_axi_awaddr;
         end else if (doWrite) begin
            awFree_reg <= 1'b1;
         end
         if (wTake) begin
            wFree_reg <= 1'b0;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            wFree_reg <= 1'b1;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wMapped ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = awFree_reg;
   assign s_axi_wready = wFree_reg;
   assign s_axi_arready = arFree_reg;

   // Read channel, one cycle from address to data
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         arFree_reg <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= csp_pkg::RESP_OKAY;
      end else if (ce) begin
         if (arTake) begin
            arFree_reg <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdOk ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            arFree_reg <= 1'b1;
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Configuration; control B is refused during a transfer
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pinFunc_reg <= csp_pkg::RST_PIN_FUNC;
         ctlA_reg <= csp_pkg::RST_CTL_A;
         misc_reg <= csp_pkg::RST_MISC;
         irqMask_reg <= csp_pkg::RST_IRQ;
         range_reg <= csp_pkg::RST_RANGE;
         idleLevel_reg <= csp_pkg::RST_IDLE_LEVEL;
      end else if (ce) begin
         if (wrPin) pinFunc_reg <= wNib; // see (R04)
         if (wrCtlA) ctlA_reg <= wNib; // see (R04) see (R05)
         if (wrMisc) misc_reg <= wNib;
         if (wrMask) irqMask_reg <= wNib;
         if (ctlBOpen) begin
            range_reg <= wNib[csp_pkg::CTLB_RANGE]; // see (R05)
            idleLevel_reg <= wNib[csp_pkg::CTLB_IDLE];
         end
      end
   end

   // Transfer engine
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= csp_pkg::ST_IDLE;
         cnt_reg <= csp_pkg::CNT_ZERO;
         sckPrev_reg <= 1'b1;
         irqStat_reg <= csp_pkg::RST_IRQ;
      end else if (ce) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sckPrev_reg <= sckSync;
         irqStat_reg <= irqStatNext; // see (R10)
      end
   end

   // Bus load beats a shift in the same cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= csp_pkg::RST_SHIFT;
      end else if (ce) begin
         if (wrLow) shift_reg[3:0] <= wNib; // see (R06)
         else if (wrHigh) shift_reg[7:4] <= wNib;
         else if (shiftIn) shift_reg <= {rxEn ? siSync : shift_reg[0],
            shift_reg[7:1]}; // see (R01) see (R06) see (R14)
      end
   end

   // Pin drivers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         serialOut <= csp_pkg::RST_IDLE_LEVEL; // see (R07)
         serialOutOe_b <= 1'b1;
         shiftClockOut <= 1'b1;
         shiftClockOe_b <= 1'b1;
         irq <= 1'b0;
      end else if (ce) begin
         if (idleLoad) serialOut <= wNib[csp_pkg::CTLB_IDLE]; // see (R13)
         else if (shiftOut) serialOut <= shift_reg[0]; // see (R14)
         serialOutOe_b <= ~txEn; // see (R04)
         shiftClockOut <= intClk ? preLevel : 1'b1; // see (R17)
         shiftClockOe_b <= ~intClk; // see (R04)
         irq <= |(irqStat_reg & ~irqMask_reg);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence seqLastRise;
      ce && lastRise && !wrCtlA && !stsTake;
   endsequence

   a_start_clears: assert property ( // see (R08)
      ce && stsTake && !wrCtlA |=>
         cnt_reg == csp_pkg::CNT_ZERO && state_reg == csp_pkg::ST_WAIT)
      else $error("start command did not clear counter");
   a_ctla_init: assert property ( // see (R03) see (R15)
      ce && wrCtlA |=>
         state_reg == csp_pkg::ST_IDLE && cnt_reg == csp_pkg::CNT_ZERO)
      else $error("control A write did not initialise port");
   a_abort_flag: assert property ( // see (R15)
      ce && abortXfer |=> irqStat_reg[csp_pkg::IRQ_SERIAL])
      else $error("aborted transfer did not set flag");
   a_count_step: assert property ( // see (R09)
      ce && shiftIn && !wrCtlA && !stsTake |=>
         cnt_reg == $past(cnt_reg) + 3'h1)
      else $error("counter did not step on rising clock");
   a_eighth_done: assert property ( // see (R10) see (R18)
      seqLastRise |=> cnt_reg == csp_pkg::CNT_ZERO &&
         irqStat_reg[csp_pkg::IRQ_SERIAL] && state_reg != csp_pkg::ST_XFER)
      else $error("eighth clock did not end transfer");
   a_int_clock_stop: assert property ( // see (R17)
      (seqLastRise and intClk) |=> state_reg == csp_pkg::ST_IDLE ##1
         (!$past(ce) || shiftClockOut) ##1 !u_prescaler.tick)
      else $error("internal clock kept running after eight");
   a_lsb_out: assert property ( // see (R14)
      ce && shiftOut |=> serialOut == $past(shift_reg[0]))
      else $error("transmit bit not LSB on falling edge");
   a_rx_sample: assert property ( // see (R14) see (R06)
      ce && shiftIn && rxEn && !wrLow && !wrHigh |=>
         shift_reg[7] == $past(siSync))
      else $error("receive bit not sampled on rising edge");
   a_idle_level: assert property ( // see (R13)
      ce && ctlBOpen && state_reg == csp_pkg::ST_IDLE |=>
         serialOut == $past(wNib[csp_pkg::CTLB_IDLE]))
      else $error("idle level not applied");
   a_cont_mode: assert property ( // see (R12)
      ce && state_reg == csp_pkg::ST_WAIT && sckFall && contMode &&
         !wrCtlA && !stsTake |=> state_reg == csp_pkg::ST_CONT [*1])
      else $error("continuous clock mode not entered");
   a_clock_pin_role: assert property ( // see (R04) see (R02)
      ce && intClk |=> !shiftClockOe_b)
      else $error("clock pin not driven in internal mode");
endmodule
`default_nettype wire

// ### tb/csp_peer.sv
// Behavioural external serial peer on the data and clock pins
`timescale 1ns/1ps
`default_nettype none
module csp_peer #(
   parameter int HALF = 8
) (
   input wire logic mclk,
   input wire logic sck,
   input wire logic so,
   input wire logic [7:0] txByte,
   input wire logic extGo,
   output logic extClk,
   output logic si,
   output logic [7:0] rxByte
);
   logic [2:0] bitIdx = 3'h0;
   initial extClk = 1'b1;
   initial si = 1'b0;
   initial rxByte = 8'h00;
   // Exactly eight pulses, clock parked high between frames
   always @(posedge extGo) begin
      repeat (8) begin
         repeat (HALF) @(posedge mclk);
         extClk <= 1'b0;
         repeat (HALF) @(posedge mclk);
         extClk <= 1'b1;
      end
   end
   always @(negedge sck) begin
      si <= txByte[bitIdx];
      bitIdx <= bitIdx + 3'h1;
   end
   // Hold time spent: show the inverse so no stale bit can pass
   always @(posedge sck) begin
      rxByte <= {so, rxByte[7:1]};
      repeat (4) @(posedge mclk);
      si <= ~si;
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Register-level tests of the clocked serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
$display("MISMATCH at %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   logic mclk = 1'b0, rst_b = 1'b0, extGo = 1'b0;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00, rxByte;
   logic [31:0] wData = 32'h0, rData, d;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
   logic arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, irq, extClk, si;
   logic [1:0] bResp, rResp, r;
   logic sckOut, sckOe_b, serialOut, serialOutOe_b;
   wire logic sckWire, soWire;
   int failures = 0, checks_done = 0;
   always #10 mclk = ~mclk;
   assign sckWire = sckOe_b ? extClk : sckOut;
   assign soWire = serialOutOe_b ? 1'b1 : serialOut;
   csp_serial_port dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .shiftClockIn(sckWire),
      .shiftClockOut(sckOut), .shiftClockOe_b(sckOe_b), .serialIn(si),
      .serialOut(serialOut), .serialOutOe_b(serialOutOe_b), .irq(irq));
   csp_peer #(.HALF(8)) peer (.mclk(mclk), .sck(sckWire), .so(soWire),
      .txByte(8'h3C), .extGo(extGo), .extClk(extClk), .si(si), .rxByte(rxByte));
   task automatic wr(input logic [5:0] i, input logic [31:0] v);
      logic a, w;
      a = 1'b1;
      w = 1'b1;
      @(posedge mclk);
      awAddr <= {i, 2'b00};
      wData <= v;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge mclk);
         if (a && awReady === 1'b1) begin
            a = 1'b0;
            awValid <= 1'b0;
         end
         if (w && wReady === 1'b1) begin
            w = 1'b0;
            wValid <= 1'b0;
         end
      end while (a || w || bValid !== 1'b1);
      r = bResp;
      bReady <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i);
      @(posedge mclk);
      arAddr <= {i, 2'b00};
      arValid <= 1'b1;
      rReady <= 1'b1;
      do @(posedge mclk); while (arReady !== 1'b1);
      arValid <= 1'b0;
      do @(posedge mclk); while (rValid !== 1'b1);
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask
   task automatic put(input logic [5:0] i, input logic [31:0] v);
      wr(i, v);
      `CHK(r, csp_pkg::RESP_OKAY)
   endtask
   task automatic get(input logic [5:0] i, input logic [7:0] e);
      rd(i);
      `CHK(r, csp_pkg::RESP_OKAY)
      `CHK(d[7:0], e)
   endtask
   task automatic waitIrq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      `CHK(irq, 1'b1)
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      get(csp_pkg::IDX_PIN_FUNC, 8'h00);
      get(csp_pkg::IDX_CTL_A, 8'h00);
      get(csp_pkg::IDX_SHIFT_LOW, 8'h00);
      get(csp_pkg::IDX_STATUS, 8'h00);
      rd(6'h3F);
      `CHK(r, csp_pkg::RESP_SLVERR)
      wr(6'h3E, 32'h1);
      `CHK(r, csp_pkg::RESP_SLVERR)
      put(csp_pkg::IDX_MISC, 32'hA);
      get(csp_pkg::IDX_MISC, 8'h0A);
      `CHK({sckOut, irq}, 2'b10)
      $display("test registers finished");
      // Idle output level follows the control bit at once
      put(csp_pkg::IDX_CTL_B, 32'h0);
      repeat (2) @(posedge mclk);
      `CHK(serialOut, 1'b0)
      put(csp_pkg::IDX_CTL_B, 32'h2);
      repeat (2) @(posedge mclk);
      `CHK(serialOut, 1'b1)
      $display("test idle level finished");
      put(csp_pkg::IDX_CTL_A, 32'hC);
      put(csp_pkg::IDX_PIN_FUNC, 32'h3);
      put(csp_pkg::IDX_SHIFT_LOW, 32'h5);
      put(csp_pkg::IDX_SHIFT_HIGH, 32'hA);
      put(csp_pkg::IDX_START, 32'h1);
      waitIrq();
      `CHK({rxByte, sckOut}, 9'h14B)
      get(csp_pkg::IDX_SHIFT_LOW, 8'h0C);
      get(csp_pkg::IDX_SHIFT_HIGH, 8'h03);
      get(csp_pkg::IDX_STATUS, 8'h00);
      get(csp_pkg::IDX_IRQ_STAT, 8'h04);
      put(csp_pkg::IDX_IRQ_MASK, 32'h4);
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0)
      put(csp_pkg::IDX_IRQ_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b1)
      put(csp_pkg::IDX_IRQ_STAT, 32'h4);
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0)
      $display("test internal clock finished");
      put(csp_pkg::IDX_CTL_A, 32'h0);
      put(csp_pkg::IDX_PIN_FUNC, 32'h1);
      put(csp_pkg::IDX_SHIFT_LOW, 32'h6);
      put(csp_pkg::IDX_SHIFT_HIGH, 32'h9);
      put(csp_pkg::IDX_START, 32'h1);
      extGo <= 1'b1;
      waitIrq();
      extGo <= 1'b0;
      `CHK(rxByte, 8'h96)
      get(csp_pkg::IDX_SHIFT_LOW, 8'h06);
      get(csp_pkg::IDX_STATUS, 8'h08);
      put(csp_pkg::IDX_IRQ_STAT, 32'h4);
      $display("test external clock finished");
      put(csp_pkg::IDX_PIN_FUNC, 32'h2);
      put(csp_pkg::IDX_CTL_A, 32'h0);
      put(csp_pkg::IDX_START, 32'h1);
      extGo <= 1'b1;
      waitIrq();
      extGo <= 1'b0;
      `CHK({rxByte, serialOutOe_b}, 9'h1FF)
      get(csp_pkg::IDX_SHIFT_LOW, 8'h0C);
      get(csp_pkg::IDX_SHIFT_HIGH, 8'h03);
      put(csp_pkg::IDX_IRQ_STAT, 32'h4);
      $display("test receive finished");
      // Abort in mid transfer still raises the flag
      put(csp_pkg::IDX_CTL_A, 32'hC);
      put(csp_pkg::IDX_START, 32'h1);
      repeat (30) @(posedge mclk);
      rd(csp_pkg::IDX_STATUS);
      `CHK(d[4:3], 2'h2)
      put(csp_pkg::IDX_CTL_A, 32'hC);
      get(csp_pkg::IDX_STATUS, 8'h00);
      get(csp_pkg::IDX_IRQ_STAT, 8'h04);
      $display("test abort finished");
      put(csp_pkg::IDX_PIN_FUNC, 32'h0);
      put(csp_pkg::IDX_CTL_A, 32'hE);
      put(csp_pkg::IDX_START, 32'h1);
      repeat (10) @(posedge mclk);
      rd(csp_pkg::IDX_STATUS);
      `CHK({d[4:3], sckOe_b}, 3'h6)
      put(csp_pkg::IDX_CTL_A, 32'h0);
      get(csp_pkg::IDX_STATUS, 8'h00);
      $display("test continuous clock finished");
      close_out();
   end
endmodule
`default_nettype wire
